// ---- rtl/jcc_top.sv ----
// Boundary-scan configuration loader with chain-enable handshake and Wishbone registers
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module jcc_top
    import jcc_pkg::*;
#(
    parameter int BITSTREAM_BITS = BITSTREAM_BITS_DEF,
    parameter int INIT_CYCLES = INIT_TCK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tck_i,
    input wire logic tdi_i,
    output logic tdo_o,
    input wire logic chain_enable_in_n_i,
    output logic chain_enable_out_n_o,
    input wire logic config_request_n_i,
    input wire logic config_complete_i,
    output logic config_complete_o,
    output logic config_complete_oe_o,
    input wire logic config_status_n_i,
    output logic config_status_n_o,
    output logic config_status_n_oe_o,
    input wire logic [3:0] scheme_select_i,
    output logic user_mode_o
);
    // Counters are CNT_W wide; refuse sizes they cannot reach
    generate
        if (BITSTREAM_BITS < 2 || BITSTREAM_BITS >= (1 << CNT_W)) begin : g_bad_bits
            $error("BITSTREAM_BITS out of range");
        end
        if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << CNT_W)) begin : g_bad_init
            $error("INIT_CYCLES out of range");
        end
    endgenerate

    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(BITSTREAM_BITS - 1);
    localparam logic [CNT_W-1:0] LAST_INIT = CNT_W'(INIT_CYCLES - 1);

    logic [9:0] pins_s;
    logic tck_s;
    logic tdi_s;
    logic ce_in_n_s;
    logic req_n_s;
    logic done_line_s;
    logic status_line_s;
    logic tck_prev_r;
    logic tck_rise;
    jcc_state_e state_r;
    logic [CNT_W-1:0] bit_cnt_r;
    logic [CNT_W-1:0] init_cnt_r;
    logic [31:0] shift_r;
    logic bypass_en_r;
    logic restart_r;
    logic bypass_r;
    logic ceo_r;
    logic done_oe_r;
    logic status_oe_r;
    logic user_r;
    logic [3:0] scheme_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic bus_req;
    logic hold_reset;

    function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] v);
        cnt_inc = v + CNT_W'(1);
    endfunction

    // All pins come from outside this clock's domain, the scheme strap included
    jcc_sync #(
        .WIDTH(10)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({scheme_select_i, tck_i, tdi_i, chain_enable_in_n_i, config_request_n_i, config_complete_i,
              config_status_n_i}),
        .q_o(pins_s)
    );

    assign tck_s = pins_s[5];
    assign tdi_s = pins_s[4];
    assign ce_in_n_s = pins_s[3];
    assign req_n_s = pins_s[2];
    assign done_line_s = pins_s[1];
    assign status_line_s = pins_s[0];

    // Test clock edge detector on the settled copy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tck_prev_r <= 1'b0;
        end else begin
            tck_prev_r <= tck_s;
        end
    end
    assign tck_rise = tck_s & ~tck_prev_r;

    // A low request or a software restart returns the loader to idle
    assign hold_reset = ~req_n_s | restart_r;

    // Loader sequence: stream bits, then initialization clocks, then done
    always_ff @(posedge clk_i) begin
        if (rst_i || hold_reset) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= '0;
            init_cnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (!bypass_en_r && !ce_in_n_s) begin
                        state_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (ce_in_n_s) begin
                        state_r <= ST_ERROR;
                    end else if (tck_rise && !bypass_en_r) begin
                        if (bit_cnt_r == '0 && tdi_s) begin
                            state_r <= ST_ERROR;
                        end else if (bit_cnt_r == LAST_BIT) begin
                            state_r <= ST_INIT;
                            init_cnt_r <= '0;
                        end
                        bit_cnt_r <= cnt_inc(bit_cnt_r);
                    end
                end
                ST_INIT: begin
                    // Host keeps clocking after the stream so startup can finish;
                    // bypass clocks belong to other devices and are not counted
                    if (tck_rise && !bypass_en_r) begin
                        init_cnt_r <= cnt_inc(init_cnt_r);
                        if (init_cnt_r == LAST_INIT) begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    state_r <= ST_DONE;
                end
                ST_ERROR: begin
                    state_r <= ST_ERROR;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Last 32 stream bits, kept for software to inspect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_r <= '0;
        end else if (state_r == ST_SHIFT && tck_rise && !bypass_en_r) begin
            shift_r <= {shift_r[30:0], tdi_s};
        end
    end

    // One-stage bypass path; the loader ignores clocks meanwhile
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bypass_r <= 1'b0;
        end else if (bypass_en_r && tck_rise) begin
            bypass_r <= tdi_s;
        end
    end
    assign tdo_o = bypass_r;

    // Handshake pins; open-drain lines are driven low only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ceo_r <= 1'b1;
            done_oe_r <= 1'b1;
            status_oe_r <= 1'b1;
            user_r <= 1'b0;
        end else begin
            ceo_r <= (state_r != ST_DONE);
            done_oe_r <= (state_r != ST_DONE);
            status_oe_r <= (state_r == ST_ERROR) | ~req_n_s;
            // Shared lines rise only when every device has released them
            user_r <= (state_r == ST_DONE) & done_line_s & status_line_s;
        end
    end
    assign chain_enable_out_n_o = ceo_r;
    assign config_complete_o = 1'b0;
    assign config_complete_oe_o = done_oe_r;
    assign config_status_n_o = 1'b0;
    assign config_status_n_oe_o = status_oe_r;
    assign user_mode_o = user_r;

    // Scheme select is a strap; it reads zero until the synchroniser has settled after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scheme_r <= '0;
        end else begin
            scheme_r <= pins_s[9:6];
        end
    end

    // Wishbone classic slave, one wait state, ack dropped the next cycle
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req;
        end
    end
    assign wb_ack_o = ack_r;

    // Control writes land at the edge where the master sees ack, while it still holds the request;
    // restart is a one-cycle pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bypass_en_r <= CTRL_BYPASS_RST;
            restart_r <= 1'b0;
        end else begin
            restart_r <= 1'b0;
            if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
                bypass_en_r <= wb_dat_i[CTRL_BYPASS_BIT];
                restart_r <= wb_dat_i[CTRL_RESTART_BIT];
            end
        end
    end

    // Read mux; unmapped addresses answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (bus_req && !wb_we_i) begin
            rdata_r <= '0;
            case (wb_adr_i)
                ADDR_CTRL: begin
                    rdata_r[CTRL_BYPASS_BIT] <= bypass_en_r;
                end
                ADDR_STATUS: begin
                    rdata_r[STAT_DONE_BIT] <= (state_r == ST_DONE);
                    rdata_r[STAT_ERROR_BIT] <= (state_r == ST_ERROR);
                    rdata_r[STAT_USER_BIT] <= user_r;
                    rdata_r[STAT_CEO_BIT] <= ceo_r;
                    rdata_r[STAT_STATE_LSB +: 3] <= state_r;
                    rdata_r[STAT_SCHEME_LSB +: 4] <= scheme_r;
                end
                ADDR_COUNT: begin
                    rdata_r <= {init_cnt_r, bit_cnt_r};
                end
                ADDR_SHIFT: begin
                    rdata_r <= shift_r;
                end
                default: begin
                    rdata_r <= '0;
                end
            endcase
        end
    end
    assign wb_dat_o = rdata_r;

    // Checks on the loader, its handshake pins, the bypass path and the Wishbone ack
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_last_init;
        state_r == ST_INIT && tck_rise && !bypass_en_r && init_cnt_r == LAST_INIT && !hold_reset;
    endsequence
    sequence s_bad_header;
        state_r == ST_SHIFT && !ce_in_n_s && tck_rise && !bypass_en_r && bit_cnt_r == '0 && tdi_s && !hold_reset;
    endsequence
    sequence s_done_held;
        state_r == ST_DONE [*2];
    endsequence

    chk_done_rise: assert property (s_last_init |=> state_r == ST_DONE ##1 !config_complete_oe_o)
        else $error("complete not raised after init clocks");
    chk_chain_abort: assert property (state_r == ST_SHIFT && ce_in_n_s && !hold_reset |=> state_r == ST_ERROR)
        else $error("chain enable high during load not refused");
    chk_ceo_low: assert property (s_done_held |-> !chain_enable_out_n_o)
        else $error("chain enable out not low after done");
    chk_ceo_high: assert property (state_r != ST_DONE |=> chain_enable_out_n_o)
        else $error("chain enable out low before done");
    chk_user_mode: assert property (user_mode_o |-> $past(state_r == ST_DONE && done_line_s && status_line_s))
        else $error("user mode without shared lines high");
    chk_request_reset: assert property (!req_n_s |=>
        state_r == ST_IDLE ##1 (config_status_n_oe_o || $past(req_n_s)))
        else $error("request low did not reset loader");
    chk_no_compress: assert property (s_bad_header |=> state_r == ST_ERROR ##1 config_status_n_oe_o)
        else $error("compressed stream accepted");
    chk_bypass_delay: assert property (bypass_en_r && tck_rise |=> tdo_o == $past(tdi_s))
        else $error("bypass data not one clock late");
    chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack timing wrong");
endmodule
`default_nettype wire

// ---- rtl/jcc_pkg.sv ----
// Package with register map, field layout and timing counts of the chain handshake loader
// How it works
// - Raise the configuration-complete output once loading finishes without fault.
// - After completing configuration, drive chain-enable output low to start the next device.
// - Shared completion and status lines make all devices enter user mode together.
// - No decompression here; a stream flagged as compressed is refused.
// - In bypass, test data passes through one register, one test clock late.
package jcc_pkg;
    // Register byte addresses on the Wishbone slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_SHIFT = 8'h0c;
    // Control register fields
    localparam int CTRL_BYPASS_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam logic CTRL_BYPASS_RST = 1'b0;
    // Status register fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_ERROR_BIT = 1;
    localparam int STAT_USER_BIT = 2;
    localparam int STAT_CEO_BIT = 3;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_SCHEME_LSB = 8;
    // Loader sizes and timing
    localparam int BITSTREAM_BITS_DEF = 256;
    localparam int INIT_TCK_CYCLES = 3180;
    localparam int CNT_W = 16;
    // Loader states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_INIT,
        ST_DONE,
        ST_ERROR
    } jcc_state_e;
endpackage

// ---- rtl/jcc_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module jcc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // First stage feeds only the second; metastability settles there
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept each bit only when the two settled stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    q_o[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/jcc_host_model.sv ----
// Boundary-scan host model driving test clock and data toward the loader
`timescale 1ns/1ps
`default_nettype none
module jcc_host_model (
    output logic tck_o,
    output logic tdi_o
);
    // Test clock rests low between frames; one device only, so no board buffer is needed
    initial begin
        tck_o = 1'b0;
        tdi_o = 1'b0;
    end
    // One 125 ns test clock; data is set half a period before the rise
    task automatic tck_bit(input logic b);
        tdi_o = b;
        #62.5 tck_o = 1'b1;
        #62.5 tck_o = 1'b0;
    endtask
    // Stream goes first bit first; a low first bit marks it uncompressed
    task automatic send(input logic [31:0] bits, input int n);
        for (int i = 0; i < n; i++) tck_bit(bits[i]);
        tdi_o = ~tdi_o; // Released line must not keep showing the last bit
    endtask
    // Extra clocks after the stream so the device can initialise
    task automatic init_clocks(input int n);
        for (int i = 0; i < n; i++) tck_bit(~tdi_o);
    endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the chain handshake loader
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import jcc_pkg::*;
    localparam int BITS = 8;
    localparam int INITC = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rdat_q, bits;
    logic ack, tck, tdi, tdo, ceo_n, cc_oe, st_oe, user, b, cc_o, st_o;
    logic exp_q[$];
    logic ce_in_n = 1'b1;
    logic req_n = 1'b0;
    logic peer_low = 1'b0;
    logic [3:0] scheme = 4'h0;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int sh = 0;
    always #5 clk_i = ~clk_i;
    jcc_host_model host (.tck_o(tck), .tdi_o(tdi));
    // Lines are pulled up; completion is shared with one peer status stays private
    jcc_top #(.BITSTREAM_BITS(BITS), .INIT_CYCLES(INITC)) i_jcc_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tck_i(tck), .tdi_i(tdi), .tdo_o(tdo), .chain_enable_in_n_i(ce_in_n),
        .chain_enable_out_n_o(ceo_n), .config_request_n_i(req_n),
        .config_complete_i(cc_oe ? cc_o : !peer_low), .config_complete_o(cc_o), .config_complete_oe_o(cc_oe),
        .config_status_n_i(st_oe ? st_o : 1'b1), .config_status_n_o(st_o), .config_status_n_oe_o(st_oe),
        .scheme_select_i(scheme), .user_mode_o(user));
    function automatic logic [31:0] st_word(input jcc_state_e s, input logic ceo, input logic um);
        st_word = {20'h0, scheme, 1'b0, s, ceo, um, s == ST_ERROR, s == ST_DONE};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] act, input logic [31:0] exp, input string what);
        n_checks++;
        if (act !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, what, act, exp);
        end
    endtask
    task automatic chk_pin(input logic act, input logic exp, input string what);
        n_checks++;
        if (act !== exp) begin
            errors++;
            $display("CHECK FAILED %0t pin %s got %b", $time, what, act);
        end
    endtask
    // Classic single cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat_q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        wb(1'b0, a, 32'h0);
        chk_reg(rdat_q, e, what);
    endtask
    // Synchroniser latency is a few clocks; eight leaves margin
    task automatic settle;
        repeat (8) @(posedge clk_i);
    endtask
    // Hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(92289));
        scheme <= 4'($urandom); // Straps never float
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk_pin(ceo_n, 1'b1, "ceo idle");
        chk_pin(cc_oe, 1'b1, "done held");
        chk_pin(user, 1'b0, "user idle");
        chk_pin(cc_o, 1'b0, "done drive level");
        chk_pin(st_o, 1'b0, "status drive level");
        rd(ADDR_CTRL, 32'h0, "ctrl reset");
        rd(8'h10, 32'h0, "unmapped");
        wb(1'b1, ADDR_STATUS, $urandom);
        rd(ADDR_STATUS, st_word(ST_IDLE, 1'b1, 1'b0), "status ro");
        req_n <= 1'b1;
        settle();
        ce_in_n <= 1'b0; // First device, enable tied low
        settle();
        rd(ADDR_STATUS, st_word(ST_SHIFT, 1'b1, 1'b0), "shift entry");
        host.send(32'h1, 1);
        rd(ADDR_STATUS, st_word(ST_ERROR, 1'b1, 1'b0), "compressed");
        chk_pin(st_oe, 1'b1, "status low");
        ce_in_n <= 1'b1;
        settle();
        wb(1'b1, ADDR_CTRL, 32'h2);
        rd(ADDR_STATUS, st_word(ST_IDLE, 1'b1, 1'b0), "restart");
        ce_in_n <= 1'b0;
        settle();
        host.send(32'h0, 3);
        @(posedge clk_i);
        ce_in_n <= 1'b1;
        settle();
        rd(ADDR_STATUS, st_word(ST_ERROR, 1'b1, 1'b0), "enable lost");
        req_n <= 1'b0;
        settle();
        chk_pin(st_oe, 1'b1, "request low");
        req_n <= 1'b1;
        settle();
        rd(ADDR_STATUS, st_word(ST_IDLE, 1'b1, 1'b0), "request reset");
        // Good load: stream captured newest bit lowest
        bits = $urandom;
        bits[0] = 1'b0;
        for (int i = 0; i < BITS; i++) exp_q.push_back(bits[i]);
        while (exp_q.size() > 0) sh = (sh << 1) | int'(exp_q.pop_front());
        ce_in_n <= 1'b0;
        settle();
        host.send(bits, BITS);
        rd(ADDR_STATUS, st_word(ST_INIT, 1'b1, 1'b0), "init");
        wb(1'b0, ADDR_SHIFT, 32'h0);
        chk_reg(rdat_q & 32'hff, 32'(sh), "stream");
        host.init_clocks(INITC - 1);
        settle();
        chk_pin(ceo_n, 1'b1, "ceo early");
        host.init_clocks(1);
        settle();
        chk_pin(ceo_n, 1'b0, "ceo done");
        chk_pin(cc_oe, 1'b0, "done release");
        chk_pin(user, 1'b1, "user");
        rd(ADDR_STATUS, st_word(ST_DONE, 1'b0, 1'b1), "done");
        peer_low <= 1'b1;
        settle();
        chk_pin(user, 1'b0, "peer busy");
        peer_low <= 1'b0;
        settle();
        chk_pin(user, 1'b1, "peer done");
        // Bypass: data one test clock late, loader untouched
        wb(1'b1, ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL, 32'h1, "bypass on");
        for (int i = 0; i < 6; i++) begin
            b = 1'($urandom);
            exp_q.push_back(b);
            host.tck_bit(b);
            chk_pin(tdo, exp_q.pop_front(), "bypass data");
        end
        rd(ADDR_STATUS, st_word(ST_DONE, 1'b0, 1'b1), "bypass hold");
        // Second reset mid-run: pins return to idle, then the still-enabled loader rearms
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk_pin(ceo_n, 1'b1, "ceo after reset");
        chk_pin(cc_oe, 1'b1, "done after reset");
        chk_pin(tdo, 1'b0, "tdo after reset");
        rd(ADDR_STATUS, st_word(ST_SHIFT, 1'b1, 1'b0), "reload");
        report_and_stop();
    end
endmodule
`default_nettype wire
